// ===== verilog/fsp_pkg.sv
// Constants, types and shared decoders for the security and parameter-table commands.
// Assumes an 8-bit opcode framing, with counts of bits taken since select fell.
// Notes on behaviour
// - Table read: 5Ah, address, dummies, data at clock 40
// - Table read uses only low address byte
// - Table read refused in quad command mode
// - Erase 44h needs write permit latch set
// - Register chosen by address bits 15 to 12
// - Erase runs only with exactly 32 bits
// - Erase self-timed, busy shown, status still readable
// - Finished erase clears the write permit latch
// - Locked register ignores erase forever
// - Program 42h, one to 256 bytes, permit needed
// - Locked register ignores program
// - Security read 48h, dummies, data until select rises
// - Read address wraps FFh to 00h, same register
// - Parameter setting only accepted in quad mode
// - Programmable dummies only for quad fast reads
// - Defaults: 8-byte wrap, 2 dummy clocks
// - Latency bits pick 2, 4, 6, 8 clocks
// - Burst bits pick 8, 16, 32, 64 bytes
// - SPI wrap from 77h, kept into quad mode; here quad wrap length follows the burst bits instead
// - Quad mode entered only by 38h with enable
// - Software reset restores volatile settings
package fsp_pkg;

  // ********************************************************************
  // opcodes
  // ********************************************************************
  localparam logic [7:0] OP_READ_TABLE     = 8'h5A;
  localparam logic [7:0] OP_SEC_ERASE      = 8'h44;
  localparam logic [7:0] OP_SEC_PROGRAM    = 8'h42;
  localparam logic [7:0] OP_SEC_READ       = 8'h48;
  localparam logic [7:0] OP_SET_READ_PARAM = 8'hC0;
  localparam logic [7:0] OP_ENTER_QUAD     = 8'h38;
  localparam logic [7:0] OP_EXIT_QUAD      = 8'hFF;
  localparam logic [7:0] OP_RESET_ENABLE   = 8'h66;
  localparam logic [7:0] OP_RESET          = 8'h99;
  localparam logic [7:0] OP_WRITE_ENABLE   = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE  = 8'h04;
  localparam logic [7:0] OP_READ_STATUS    = 8'h05;
  localparam logic [7:0] OP_SET_WRAP       = 8'h77;

  // ********************************************************************
  // frame bit counts
  // ********************************************************************
  localparam logic [5:0] BITS_OPCODE     = 6'h08;
  localparam logic [5:0] BITS_PARAM_END  = 6'h10;
  localparam logic [5:0] BITS_ADDR_END   = 6'h20;
  localparam logic [5:0] BITS_DATA_START = 6'h28;
  localparam logic [5:0] BITS_MAX        = 6'h3F;
  localparam logic [5:0] STEP_SPI        = 6'h01;
  localparam logic [5:0] STEP_QUAD       = 6'h04;
  localparam logic [2:0] BIT_LAST        = 3'h7;

  // ********************************************************************
  // fields, defaults and values
  // ********************************************************************
  localparam int         LAT_HI = 5;
  localparam int         LAT_LO = 4;
  localparam int         BURST_HI = 1;
  localparam int         BURST_LO = 0;
  localparam int         WRAP_HI = 6;
  localparam int         WRAP_LO = 4;
  localparam int         SEL_HI = 15;
  localparam int         SEL_LO = 12;
  localparam logic [1:0] LATENCY_DEFAULT  = 2'h0;
  localparam logic [1:0] BURST_DEFAULT    = 2'h0;
  localparam logic [2:0] SPI_WRAP_DEFAULT = 3'h4;
  localparam logic [3:0] SPI_DUMMY_CLOCKS = 4'h8;
  localparam logic [3:0] DUMMY_BASE       = 4'h2;
  localparam logic [6:0] WRAP_BASE        = 7'h08;
  localparam logic [7:0] ERASED_BYTE      = 8'hFF;
  localparam logic [7:0] ADDR_HIGH_ZERO   = 8'h00;
  localparam logic [3:0] ADDR_MID_ZERO    = 4'h0;
  localparam int         SEC_BYTES        = 256;
  localparam int         SEC_TOTAL        = 768;
  localparam logic [1:0] SEL_NONE         = 2'h0;

  // ********************************************************************
  // timing
  // ********************************************************************
  localparam int CLK_MHZ            = 100;
  localparam int SEC_ERASE_TIME_US  = 100; // secure_erase_time, plain default

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ERASE = 2'b01,
    ST_WIPE  = 2'b10
  } fsp_state_t;

  // security register number 1..3 from a 24-bit address, 0 when invalid
  function automatic logic [1:0] sec_select(input logic [23:0] addr);
    logic [3:0] sel;
    sel = addr[SEL_HI:SEL_LO];
    if (addr[23:16] != ADDR_HIGH_ZERO || addr[11:8] != ADDR_MID_ZERO ||
        sel == 4'h0 || sel > 4'h3)
      return SEL_NONE;
    return sel[1:0];
  endfunction

  // true when a register is invalid or its lock bit is set
  function automatic logic sec_blocked(input logic [1:0] sel, input logic [2:0] lock);
    logic [1:0] idx;
    idx = sel - 2'h1;
    return (sel == SEL_NONE) || lock[idx];
  endfunction

  // flat storage index of a byte in a security register
  function automatic logic [9:0] sec_index(input logic [1:0] sel, input logic [7:0] byteAddr);
    logic [1:0] idx;
    idx = sel - 2'h1;
    return {idx, byteAddr};
  endfunction

endpackage

// ===== verilog/fsp_security_cmds.sv
// Command logic for the parameter table, security registers and read settings.
// Assumes the link clock stops while select is high, and that select stays
// high for at least 8 mclk cycles between frames.
`timescale 1ns/100ps
`default_nettype none
module fsp_security_cmds #(
  parameter int ERASE_CYCLES = fsp_pkg::SEC_ERASE_TIME_US * fsp_pkg::CLK_MHZ
) (
  // system
  input  wire  logic       mclk,
  input  wire  logic       rst,
  // serial link
  input  wire  logic       linkClk,
  input  wire  logic       selectN,
  input  wire  logic [3:0] ioIn,
  output logic       [3:0] ioOut,
  output logic       [3:0] ioOeN,
  // status bits from the second status register
  input  wire  logic [2:0] otpLockBits,
  input  wire  logic       quadEnableBit,
  // state and settings
  output logic             busy,
  output logic             writePermitLatch,
  output logic             quadCommandMode,
  output logic       [1:0] latencySelect,
  output logic       [1:0] burstLengthSelect,
  output logic       [2:0] spiWrapSelect,
  output logic       [3:0] readDummyClocks,
  output logic       [6:0] wrapLengthBytes
);

  // ********************************************************************
  // link domain
  // ********************************************************************
  logic        linkRst;
  logic [5:0]  bitCnt;
  logic [2:0]  riseCnt;
  logic [31:0] shiftIn;
  logic [5:0]  next_bitCnt;
  logic [31:0] next_shift;
  logic [7:0]  opNow;
  logic        byteEdge;
  logic [7:0]  frameOp;
  logic [23:0] frameAddr;
  logic [7:0]  frameParam;
  logic [5:0]  frameBits;
  logic        frameTag;
  logic [1:0]  frameSel;
  logic [7:0]  byteAddr;
  logic [7:0]  txShift;
  logic        txOn;
  logic        reqTog;
  logic        reqWrite;
  logic [1:0]  reqSel;
  logic [7:0]  reqByte;
  logic [7:0]  reqData;
  logic [1:0]  statS1;
  logic [1:0]  statS2;
  logic        ackS1;
  logic        ackS2;

  // mclk-domain signals seen by the link
  logic        ackTog;
  logic [7:0]  rdData;

  assign linkRst = rst | selectN;

  // table contents; the signature bytes spell SFDP, all other bytes read FFh
  function automatic logic [7:0] table_byte(input logic [7:0] a);
    case (a)
      8'h00:   return 8'h53;
      8'h01:   return 8'h46;
      8'h02:   return 8'h44;
      8'h03:   return 8'h50;
      default: return fsp_pkg::ERASED_BYTE;
    endcase
  endfunction

  // next bit count and input shift; quad mode takes a nibble per clock
  always_comb begin
    logic [6:0] sum;
    sum = 7'h00;
    sum = {1'b0, bitCnt} + {1'b0, quadCommandMode ? fsp_pkg::STEP_QUAD : fsp_pkg::STEP_SPI};
    next_bitCnt = (sum > {1'b0, fsp_pkg::BITS_MAX}) ? fsp_pkg::BITS_MAX : sum[5:0];
    next_shift = quadCommandMode ? {shiftIn[27:0], ioIn} : {shiftIn[30:0], ioIn[0]};
    opNow = (next_bitCnt == fsp_pkg::BITS_OPCODE) ? next_shift[7:0] : frameOp;
    byteEdge = (riseCnt == fsp_pkg::BIT_LAST);
  end

  // bit counters, cleared while select is high
  always_ff @(posedge linkClk or posedge linkRst) begin
    if (linkRst) begin
      bitCnt  <= 6'h00;
      riseCnt <= 3'h0;
      shiftIn <= 32'h0000_0000;
    end else begin
      bitCnt  <= next_bitCnt;
      riseCnt <= riseCnt + 3'h1;
      shiftIn <= next_shift;
    end
  end

  // frame summary, held after select rises for the mclk side to decode
  always_ff @(posedge linkClk or posedge rst) begin
    if (rst) begin
      frameOp    <= 8'h00;
      frameAddr  <= 24'h00_0000;
      frameParam <= 8'h00;
      frameBits  <= 6'h00;
      frameTag   <= 1'b0;
    end else begin
      frameBits <= next_bitCnt;
      if (bitCnt == 6'h00)
        frameTag <= ~frameTag; // marks a frame that had clocks
      if (next_bitCnt == fsp_pkg::BITS_OPCODE)
        frameOp <= next_shift[7:0];
      if (next_bitCnt == fsp_pkg::BITS_PARAM_END)
        frameParam <= next_shift[7:0];
      if (next_bitCnt == fsp_pkg::BITS_ADDR_END)
        frameAddr <= next_shift[23:0];
    end
  end

  // byte address and target register of the current frame
  always_ff @(posedge linkClk or posedge linkRst) begin
    if (linkRst) begin
      byteAddr <= 8'h00;
      frameSel <= fsp_pkg::SEL_NONE;
    end else if (next_bitCnt == fsp_pkg::BITS_ADDR_END && !quadCommandMode) begin
      byteAddr <= next_shift[7:0];
      frameSel <= fsp_pkg::sec_select(next_shift[23:0]);
    end else if (byteEdge && next_bitCnt >= fsp_pkg::BITS_DATA_START &&
                 (opNow == fsp_pkg::OP_READ_TABLE || opNow == fsp_pkg::OP_SEC_READ ||
                  opNow == fsp_pkg::OP_SEC_PROGRAM)) begin
      byteAddr <= byteAddr + 8'h01;
    end
  end

  // output byte loading and shifting
  always_ff @(posedge linkClk or posedge linkRst) begin
    if (linkRst) begin
      txShift <= 8'h00;
      txOn    <= 1'b0;
    end else if (quadCommandMode) begin
      txOn <= 1'b0;
    end else if (byteEdge && opNow == fsp_pkg::OP_READ_STATUS &&
                 next_bitCnt >= fsp_pkg::BITS_OPCODE) begin
      txShift <= {6'h00, statS2};
      txOn    <= 1'b1;
    end else if (byteEdge && opNow == fsp_pkg::OP_READ_TABLE &&
                 next_bitCnt >= fsp_pkg::BITS_DATA_START) begin
      txShift <= table_byte(byteAddr);
      txOn    <= 1'b1;
    end else if (byteEdge && opNow == fsp_pkg::OP_SEC_READ &&
                 next_bitCnt >= fsp_pkg::BITS_DATA_START) begin
      txShift <= (ackS2 == reqTog) ? rdData : fsp_pkg::ERASED_BYTE;
      txOn    <= 1'b1;
    end else begin
      txShift <= {txShift[6:0], 1'b0};
    end
  end

  // requests to the storage side: read prefetch and program writes
  always_ff @(posedge linkClk or posedge rst) begin
    if (rst) begin
      reqTog   <= 1'b0;
      reqWrite <= 1'b0;
      reqSel   <= fsp_pkg::SEL_NONE;
      reqByte  <= 8'h00;
      reqData  <= 8'h00;
    end else if (!quadCommandMode && opNow == fsp_pkg::OP_SEC_READ &&
                 next_bitCnt == fsp_pkg::BITS_ADDR_END) begin
      reqTog   <= ~reqTog;
      reqWrite <= 1'b0;
      reqSel   <= fsp_pkg::sec_select(next_shift[23:0]);
      reqByte  <= next_shift[7:0];
    end else if (!quadCommandMode && opNow == fsp_pkg::OP_SEC_READ && byteEdge &&
                 next_bitCnt >= fsp_pkg::BITS_DATA_START) begin
      reqTog   <= ~reqTog;
      reqWrite <= 1'b0;
      reqByte  <= byteAddr + 8'h01;
    end else if (!quadCommandMode && opNow == fsp_pkg::OP_SEC_PROGRAM && byteEdge &&
                 next_bitCnt >= fsp_pkg::BITS_DATA_START && frameSel != fsp_pkg::SEL_NONE) begin
      reqTog   <= ~reqTog;
      reqWrite <= 1'b1;
      reqSel   <= frameSel;
      reqByte  <= byteAddr;
      reqData  <= next_shift[7:0];
    end
  end

  // status bits and acknowledge into the link domain
  always_ff @(posedge linkClk or posedge rst) begin
    if (rst) begin
      statS1 <= 2'h0;
      statS2 <= 2'h0;
      ackS1  <= 1'b0;
      ackS2  <= 1'b0;
    end else begin
      statS1 <= {writePermitLatch, busy};
      statS2 <= statS1;
      ackS1  <= ackTog;
      ackS2  <= ackS1;
    end
  end

  // data out on the falling edge; enables are low while driving
  always_ff @(negedge linkClk or posedge linkRst) begin
    if (linkRst) begin
      ioOut <= 4'h0;
      ioOeN <= 4'hF;
    end else begin
      ioOut <= {2'h0, txShift[7], 1'b0};
      ioOeN <= txOn ? 4'hD : 4'hF;
    end
  end

  // ********************************************************************
  // mclk domain
  // ********************************************************************
  logic                csS1;
  logic                csS2;
  logic                csS3;
  logic                tagSeen;
  logic                frameEnd;
  logic                reqS1;
  logic                reqS2;
  logic                reqS3;
  logic                reqEdge;
  logic                rstArmed;
  logic [23:0]         eraseCnt;
  logic [1:0]          eraseSel;
  fsp_pkg::fsp_state_t state;
  logic [7:0]          secMem [0:fsp_pkg::SEC_TOTAL-1];

  // select and request toggle synchronisers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      csS1  <= 1'b1;
      csS2  <= 1'b1;
      csS3  <= 1'b1;
      reqS1 <= 1'b0;
      reqS2 <= 1'b0;
      reqS3 <= 1'b0;
    end else begin
      csS1  <= selectN;
      csS2  <= csS1;
      csS3  <= csS2;
      reqS1 <= reqTog;
      reqS2 <= reqS1;
      reqS3 <= reqS2;
    end
  end

  assign frameEnd = csS2 & ~csS3 & (frameTag != tagSeen);
  assign reqEdge  = reqS2 ^ reqS3;

  localparam fsp_pkg::fsp_state_t ST_WIPE_C = fsp_pkg::ST_WIPE;

  // storage: program writes and erase wipe
  always_ff @(posedge mclk) begin
    if (state == ST_WIPE_C) begin
      for (int i = 0; i < fsp_pkg::SEC_BYTES; i++)
        secMem[fsp_pkg::sec_index(eraseSel, 8'(i))] <= fsp_pkg::ERASED_BYTE;
    end else if (reqEdge && reqWrite && writePermitLatch && !busy &&
                 !fsp_pkg::sec_blocked(reqSel, otpLockBits)) begin
      secMem[fsp_pkg::sec_index(reqSel, reqByte)] <=
        secMem[fsp_pkg::sec_index(reqSel, reqByte)] & reqData;
    end
  end

  // read answers and acknowledge back to the link
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdData <= 8'h00;
      ackTog <= 1'b0;
    end else if (reqEdge) begin
      ackTog <= reqS2;
      if (!reqWrite)
        rdData <= (reqSel == fsp_pkg::SEL_NONE) ? fsp_pkg::ERASED_BYTE :
                  secMem[fsp_pkg::sec_index(reqSel, reqByte)];
    end
  end

  // command decode at the end of each frame, plus the erase sequencer
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tagSeen           <= 1'b0;
      rstArmed          <= 1'b0;
      writePermitLatch  <= 1'b0;
      quadCommandMode   <= 1'b0;
      latencySelect     <= fsp_pkg::LATENCY_DEFAULT;
      burstLengthSelect <= fsp_pkg::BURST_DEFAULT;
      spiWrapSelect     <= fsp_pkg::SPI_WRAP_DEFAULT;
      state             <= fsp_pkg::ST_IDLE;
      busy              <= 1'b0;
      eraseCnt          <= 24'h00_0000;
      eraseSel          <= fsp_pkg::SEL_NONE;
    end else begin
      case (state)
        fsp_pkg::ST_ERASE: begin
          if (eraseCnt == 24'(ERASE_CYCLES - 1))
            state <= fsp_pkg::ST_WIPE;
          else
            eraseCnt <= eraseCnt + 24'h00_0001;
        end
        fsp_pkg::ST_WIPE: begin
          state            <= fsp_pkg::ST_IDLE;
          busy             <= 1'b0;
          writePermitLatch <= 1'b0;
        end
        default: ;
      endcase
      if (frameEnd) begin
        tagSeen  <= frameTag;
        rstArmed <= 1'b0;
        if (frameOp == fsp_pkg::OP_RESET && rstArmed && frameBits == fsp_pkg::BITS_OPCODE) begin
          writePermitLatch  <= 1'b0;
          quadCommandMode   <= 1'b0;
          latencySelect     <= fsp_pkg::LATENCY_DEFAULT;
          burstLengthSelect <= fsp_pkg::BURST_DEFAULT;
          spiWrapSelect     <= fsp_pkg::SPI_WRAP_DEFAULT;
          state             <= fsp_pkg::ST_IDLE;
          busy              <= 1'b0;
        end else if (frameOp == fsp_pkg::OP_RESET_ENABLE && frameBits == fsp_pkg::BITS_OPCODE) begin
          rstArmed <= 1'b1;
        end else if (!busy) begin
          case (frameOp)
            fsp_pkg::OP_WRITE_ENABLE: begin
              if (frameBits == fsp_pkg::BITS_OPCODE)
                writePermitLatch <= 1'b1;
            end
            fsp_pkg::OP_WRITE_DISABLE: begin
              if (frameBits == fsp_pkg::BITS_OPCODE)
                writePermitLatch <= 1'b0;
            end
            fsp_pkg::OP_ENTER_QUAD: begin
              if (!quadCommandMode && quadEnableBit && frameBits == fsp_pkg::BITS_OPCODE)
                quadCommandMode <= 1'b1;
            end
            fsp_pkg::OP_EXIT_QUAD: begin
              if (quadCommandMode && frameBits == fsp_pkg::BITS_OPCODE)
                quadCommandMode <= 1'b0;
            end
            fsp_pkg::OP_SET_READ_PARAM: begin
              if (quadCommandMode && frameBits == fsp_pkg::BITS_PARAM_END) begin
                latencySelect     <= frameParam[fsp_pkg::LAT_HI:fsp_pkg::LAT_LO];
                burstLengthSelect <= frameParam[fsp_pkg::BURST_HI:fsp_pkg::BURST_LO];
              end
            end
            fsp_pkg::OP_SET_WRAP: begin
              if (!quadCommandMode && frameBits == fsp_pkg::BITS_ADDR_END)
                spiWrapSelect <= frameAddr[fsp_pkg::WRAP_HI:fsp_pkg::WRAP_LO];
            end
            fsp_pkg::OP_SEC_ERASE: begin
              if (!quadCommandMode && frameBits == fsp_pkg::BITS_ADDR_END &&
                  writePermitLatch &&
                  !fsp_pkg::sec_blocked(fsp_pkg::sec_select(frameAddr), otpLockBits)) begin
                state    <= fsp_pkg::ST_ERASE;
                busy     <= 1'b1;
                eraseCnt <= 24'h00_0000;
                eraseSel <= fsp_pkg::sec_select(frameAddr);
              end
            end
            fsp_pkg::OP_SEC_PROGRAM: begin
              if (!quadCommandMode && frameBits >= fsp_pkg::BITS_DATA_START)
                writePermitLatch <= 1'b0;
            end
            default: ;
          endcase
        end
      end
    end
  end

  // effective dummy count and wrap length for the fast read paths
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      readDummyClocks <= fsp_pkg::SPI_DUMMY_CLOCKS;
      wrapLengthBytes <= fsp_pkg::WRAP_BASE;
    end else begin
      readDummyClocks <= quadCommandMode ?
        ({1'b0, latencySelect, 1'b0} + fsp_pkg::DUMMY_BASE) :
        fsp_pkg::SPI_DUMMY_CLOCKS;
      wrapLengthBytes <= fsp_pkg::WRAP_BASE <<
        (quadCommandMode ? burstLengthSelect : spiWrapSelect[1:0]);
    end
  end

endmodule
`default_nettype wire

// ===== verilog/unused_guard.sv
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// ===== bench/fsp_security_cmds_props.sv
// Checker for the security and parameter-table command block.
// Assumes it is bound into the design and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module fsp_security_cmds_props (
  // clock and reset
  input wire logic       mclk,
  input wire logic       rst,
  // link and straps
  input wire logic       selectN,
  input wire logic [3:0] ioOeN,
  input wire logic       quadEnableBit,
  // state and settings
  input wire logic       busy,
  input wire logic       writePermitLatch,
  input wire logic       quadCommandMode,
  input wire logic [1:0] latencySelect,
  input wire logic [1:0] burstLengthSelect,
  input wire logic [2:0] spiWrapSelect,
  input wire logic [3:0] readDummyClocks,
  input wire logic [6:0] wrapLengthBytes
);
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  property p_spiDummy;
    !$past(quadCommandMode) |-> readDummyClocks == 4'h8;
  endproperty
  a_spiDummy: assert property (p_spiDummy) else $error("spi dummy count wrong");
  property p_quadDummy;
    $past(quadCommandMode) |-> readDummyClocks == 4'h2 + {1'b0, $past(latencySelect), 1'b0};
  endproperty
  a_quadDummy: assert property (p_quadDummy) else $error("quad dummy count wrong");
  property p_quadWrap;
    $past(quadCommandMode) |-> wrapLengthBytes == 7'h08 << $past(burstLengthSelect);
  endproperty
  a_quadWrap: assert property (p_quadWrap) else $error("quad wrap length wrong");
  property p_spiWrap;
    !$past(quadCommandMode) |-> wrapLengthBytes == 7'h08 << ($past(spiWrapSelect) & 3'h3);
  endproperty
  a_spiWrap: assert property (p_spiWrap) else $error("spi wrap length wrong");
  property p_quadEntry;
    $rose(quadCommandMode) |-> quadEnableBit && selectN;
  endproperty
  a_quadEntry: assert property (p_quadEntry) else $error("quad entered wrongly");
  property p_paramQuad;
    $changed(latencySelect) |-> $past(quadCommandMode) || latencySelect == 2'h0;
  endproperty
  a_paramQuad: assert property (p_paramQuad) else $error("latency set outside quad");
  property p_eraseStart;
    $rose(busy) |-> $past(writePermitLatch) && selectN;
  endproperty
  a_eraseStart: assert property (p_eraseStart) else $error("erase without permit");
  property p_eraseLen;
    $rose(busy) |-> busy [*8];
  endproperty
  a_eraseLen: assert property (p_eraseLen) else $error("erase too short");
  property p_eraseEnd;
    $fell(busy) |-> ##[0:2] !writePermitLatch;
  endproperty
  a_eraseEnd: assert property (p_eraseEnd) else $error("permit kept after erase");
  property p_oeIdle;
    selectN |-> ioOeN == 4'hF;
  endproperty
  a_oeIdle: assert property (p_oeIdle) else $error("output on while deselected");
  property p_oeShape;
    ioOeN == 4'hF || ioOeN == 4'hD;
  endproperty
  a_oeShape: assert property (p_oeShape) else $error("bad output enable");
endmodule

bind fsp_security_cmds fsp_security_cmds_props u_props (.mclk, .rst, .selectN, .ioOeN,
  .quadEnableBit, .busy, .writePermitLatch, .quadCommandMode, .latencySelect,
  .burstLengthSelect, .spiWrapSelect, .readDummyClocks, .wrapLengthBytes);
`default_nettype wire

// ===== bench/fsp_host_model.sv
// Host link model: makes the link clock only within frames, drives select and data.
// Assumes the device samples on rising and drives on falling link edges.
`timescale 1ns/100ps
`default_nettype none
module fsp_host_model (
  // link to device
  output logic             linkClk,
  output logic             selectN,
  output logic       [3:0] ioIn,
  input  wire  logic [3:0] ioOut
);
  logic [63:0] rx; // data-out line sampled at rising edges

  // idle: clock stands low, select high
  initial begin
    linkClk = 1'b0;
    selectN = 1'b1;
    ioIn    = 4'hA;
  end

  // one frame of n clocks, w bits a clock, msb first; unused lines toggle
  task automatic frame(input logic [63:0] tx, input int n, input int w);
    selectN <= 1'b0;
    for (int i = 0; i < n; i++) begin
      ioIn <= (w == 4) ? tx[63 - 4 * i -: 4] : {ioIn[3:1] ^ 3'h7, tx[63 - i]};
      #32 linkClk <= 1'b1;
      rx = {rx[62:0], ioOut[1]};
      #32 linkClk <= 1'b0;
    end
    #32 selectN <= 1'b1;
    ioIn <= ~ioIn;
    #200;
  endtask
endmodule
`default_nettype wire

// ===== bench/fsp_security_cmds_tb.sv
// Self-checking bench for the security and parameter-table commands.
// Assumes the host model and the bound checker from this folder.
`timescale 1ns/100ps
`default_nettype none
module fsp_security_cmds_tb;
  logic       mclk;
  logic       rst;
  logic       quadEnableBit;
  logic [2:0] otpLockBits;
  logic       linkClk;
  logic       selectN;
  logic [3:0] ioIn;
  logic [3:0] ioOut;
  logic [3:0] ioOeN;
  logic       busy;
  logic       writePermitLatch;
  logic       quadCommandMode;
  logic [1:0] latencySelect;
  logic [1:0] burstLengthSelect;
  logic [2:0] spiWrapSelect;
  logic [3:0] readDummyClocks;
  logic [6:0] wrapLengthBytes;
  int         errCount;
  int         nCompared;
  int         k;

  // ****************************************
  // design, host and clock
  // ****************************************
  fsp_security_cmds #(.ERASE_CYCLES(400)) DUT (.mclk, .rst, .linkClk, .selectN, .ioIn,
    .ioOut, .ioOeN, .otpLockBits, .quadEnableBit, .busy, .writePermitLatch,
    .quadCommandMode, .latencySelect, .burstLengthSelect, .spiWrapSelect,
    .readDummyClocks, .wrapLengthBytes);
  fsp_host_model host (.linkClk, .selectN, .ioIn, .ioOut);
  always #5 mclk = ~mclk;

  // compare one byte-wide result
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    nCompared++;
    if (got !== exp) begin
      errCount++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // verdict and end of run
  task automatic summarize();
    if (errCount == 0 && nCompared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // main sequence
  initial begin
    mclk = 1'b0;
    rst = 1'b1;
    quadEnableBit = 1'b0;
    otpLockBits = 3'h0;
    errCount = 0;
    nCompared = 0;
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    #1;
    cmp({busy, writePermitLatch, quadCommandMode, latencySelect, burstLengthSelect, 1'b0}, 8'h00);
    cmp({spiWrapSelect, 1'b0, readDummyClocks}, 8'h88);
    cmp({1'b0, wrapLengthBytes}, 8'h08);
    host.frame({8'h5A, 24'h0000FF, 32'h0}, 64, 1);
    cmp(host.rx[23:16], 8'hFF);
    cmp(host.rx[15:8], 8'h53);
    cmp(host.rx[7:0], 8'h46);
    host.frame({8'h44, 24'h001000, 32'h0}, 32, 1);
    cmp(8'(busy), 8'h00);
    host.frame({8'h06, 56'h0}, 8, 1);
    host.frame({8'h44, 24'h001000, 32'h0}, 33, 1);
    cmp(8'(busy), 8'h00);
    for (int r = 1; r < 4; r++) begin
      host.frame({8'h06, 56'h0}, 8, 1);
      cmp(8'(writePermitLatch), 8'h01);
      host.frame({8'h44, 8'h00, 4'(r), 12'h000, 32'h0}, 32, 1);
      cmp(8'(busy), 8'h01);
      host.frame({8'h05, 56'h0}, 24, 1);
      cmp(8'(host.rx[0]), 8'h01);
      for (k = 0; k < 2000 && busy !== 1'b0; k++) begin
        @(posedge mclk);
        #1;
      end
      if (k == 2000) begin
        cmp(8'h01, 8'h00);
        summarize();
      end
      cmp(8'(writePermitLatch), 8'h00);
    end
    host.frame({8'h06, 56'h0}, 8, 1);
    host.frame({8'h42, 24'h0020FF, 24'hA53C0F, 8'h0}, 56, 1);
    host.frame({8'h48, 24'h0020FF, 32'h0}, 64, 1);
    cmp(host.rx[23:16], 8'hA5);
    cmp(host.rx[15:8], 8'h3C);
    cmp(host.rx[7:0], 8'h0F);
    @(posedge mclk) otpLockBits <= 3'h1;
    host.frame({8'h06, 56'h0}, 8, 1);
    host.frame({8'h44, 24'h001000, 32'h0}, 32, 1);
    cmp(8'(busy), 8'h00);
    host.frame({8'h06, 56'h0}, 8, 1);
    host.frame({8'h42, 24'h001000, 32'h0}, 40, 1);
    host.frame({8'h48, 24'h001000, 32'h0}, 48, 1);
    cmp(host.rx[7:0], 8'hFF);
    host.frame({8'hC0, 8'h31, 48'h0}, 16, 1);
    cmp({6'h0, latencySelect}, 8'h00);
    host.frame({8'h77, 16'h0, 8'h10, 32'h0}, 32, 1);
    cmp({5'h0, spiWrapSelect}, 8'h01);
    cmp({1'b0, wrapLengthBytes}, 8'h10);
    host.frame({8'h38, 56'h0}, 8, 1);
    cmp(8'(quadCommandMode), 8'h00);
    @(posedge mclk) quadEnableBit <= 1'b1;
    host.frame({8'h38, 56'h0}, 8, 1);
    cmp({quadCommandMode, spiWrapSelect, readDummyClocks}, 8'h92);
    for (int i = 0; i < 4; i++) begin
      host.frame({8'hC0, 2'h0, 2'(i), 2'h0, 2'(3 - i), 48'h0}, 4, 4);
      cmp({4'h0, readDummyClocks}, 8'(2 + 2 * i));
      cmp({1'b0, wrapLengthBytes}, 8'(8 << (3 - i)));
    end
    host.frame({8'h06, 56'h0}, 2, 4);
    cmp(8'(writePermitLatch), 8'h01);
    host.frame({8'h04, 56'h0}, 2, 4);
    cmp(8'(writePermitLatch), 8'h00);
    host.frame({8'h06, 56'h0}, 2, 4);
    cmp(8'(writePermitLatch), 8'h01);
    host.frame({8'h66, 56'h0}, 2, 4);
    host.frame({8'h99, 56'h0}, 2, 4);
    cmp({busy, writePermitLatch, quadCommandMode, latencySelect, burstLengthSelect, 1'b0}, 8'h00);
    cmp({spiWrapSelect, 1'b0, readDummyClocks}, 8'h88);
    summarize();
  end
endmodule
`default_nettype wire
